// File: tsm_pkg.sv
/*
 * Constants for the timer slave-mode, event and status block: register
 * offsets, field positions, reset values and mode encodings.
 * Assumes a 32-bit APB register bus with word-aligned registers.
 */
package tsm_pkg;
    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] TSM_OFF_SMC = 8'h08;
    localparam logic [7:0] TSM_OFF_DIE = 8'h0C;
    localparam logic [7:0] TSM_OFF_STS = 8'h10;
    localparam logic [7:0] TSM_OFF_EGR = 8'h14;
    localparam logic [7:0] TSM_OFF_CTL = 8'h00;

    // ****************************************************************
    // reset values and masks
    // ****************************************************************
    localparam logic [15:0] TSM_SMC_RST = 16'h0000;
    localparam logic [15:0] TSM_DIE_RST = 16'h0000;
    localparam logic [15:0] TSM_STS_RST = 16'h0000;
    localparam logic [15:0] TSM_DIE_MASK = 16'h5F5F;
    localparam logic [15:0] TSM_STS_MASK = 16'h1E5F;
    localparam logic [3:0] TSM_CTL_RST = 4'h0;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int TSM_SMC_MSM = 7;
    localparam int TSM_SMC_TS = 4;
    localparam int TSM_SMC_CLEAR_SOURCE_SELECT = 3;
    localparam int TSM_DIE_TDE = 14;
    localparam int TSM_DIE_CCDE = 9;
    localparam int TSM_DIE_UDE = 8;
    localparam int TSM_DIE_TIE = 6;
    localparam int TSM_DIE_CCIE = 1;
    localparam int TSM_DIE_UIE = 0;
    localparam int TSM_STS_CCOF = 9;
    localparam int TSM_STS_TIF = 6;
    localparam int TSM_STS_CCIF = 1;
    localparam int TSM_STS_UIF = 0;
    localparam int TSM_CTL_CEN = 0;
    localparam int TSM_CTL_UPDATE_INHIBIT = 1;
    localparam int TSM_CTL_URS = 2;
    localparam int TSM_CTL_DIR = 3;

    // delay added to trigger effect for master/slave sync, in cycles
    localparam int TSM_SYNC_DELAY = 1;

    typedef enum logic [2:0] {
        TSM_SM_OFF = 3'h0,
        TSM_SM_ENC1 = 3'h1,
        TSM_SM_ENC2 = 3'h2,
        TSM_SM_ENC3 = 3'h3,
        TSM_SM_RESET = 3'h4,
        TSM_SM_GATED = 3'h5,
        TSM_SM_TRIG = 3'h6,
        TSM_SM_EXTCLK = 3'h7
    } tsm_mode_t;
endpackage

// File: tsm_slave_ctrl.sv
/*
 * Slave-mode controller, DMA/interrupt enables, status flags and software
 * event generation of a general-purpose timer.
 * Assumes the counter core, filters and channel logic sit outside and
 * exchange strobes with this block; all inputs synchronous to clk.
 */
// Operation
// - sync bit delays trigger effect one cycle
// - trigger source field picks trigger input
// - clear source bit picks comparator or trigger
// - mode off: counter clocked by internal clock
// - modes 1-3 are quadrature encoder modes
// - reset mode: rising trigger reinitialises counter
// - gated mode counts while trigger high
// - trigger mode starts counter on rising edge
// - external clock mode counts trigger rising edges
// - line 0 and 1 from timers; 2,3 open
// - DMA enable bits gate DMA requests
// - interrupt enable bits gate interrupts
// - overcapture only on capture with flag set
// - trigger flag on active edge, both gated
// - channel flag on match or capture; read clears
// - update flag rules with restrict and inhibit
// - status flags cleared by writing zero
// - soft trigger sets trigger flag, self-clears
// - channel soft event sets flag, may capture
// - soft update reinitialises counter and prescaler
// - inhibit blocks update but not reinitialise
// - restrict limits update requests to overflow
// - trigger mode sets counter enable itself
`timescale 1ns/1ps
module tsm_slave_ctrl
    import tsm_pkg::*;
#(
    parameter int CHANNELS = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic internalTriggerLine0,
    input wire logic internalTriggerLine1,
    input wire logic ch1EdgeDetect,
    input wire logic ch1FilteredIn,
    input wire logic ch2FilteredIn,
    input wire logic filteredExtTrigger,
    input wire logic comparatorOut,
    input wire logic overflowEvent,
    input wire logic repCountZero,
    input wire logic [CHANNELS-1:0] chanIsInput,
    input wire logic [CHANNELS-1:0] chanCompareMatch,
    input wire logic [CHANNELS-1:0] chanCaptureEvent,
    input wire logic [CHANNELS-1:0] chanCaptureRead,
    output logic counterEnable,
    output logic counterTick,
    output logic countDown,
    output logic counterReinit,
    output logic reinitLoadsReload,
    output logic updateEvent,
    output logic [CHANNELS-1:0] chanCaptureNow,
    output logic ocClear,
    output logic triggerIrq,
    output logic updateIrq,
    output logic [CHANNELS-1:0] chanIrq,
    output logic triggerDma,
    output logic updateDma,
    output logic [CHANNELS-1:0] chanDma
);
    // ****************************************************************
    // register bus
    // ****************************************************************
    logic [15:0] smc_q, die_q, sts_q, sts_d, egrWr;
    logic [3:0] ctl_q;
    logic wrAcc, hit;
    logic [2:0] modeSel, srcSel;

    assign wrAcc = psel && penable && pwrite && clkEn;
    assign hit = paddr == TSM_OFF_SMC || paddr == TSM_OFF_DIE ||
                 paddr == TSM_OFF_STS || paddr == TSM_OFF_EGR ||
                 paddr == TSM_OFF_CTL;
    assign egrWr = (wrAcc && paddr == TSM_OFF_EGR) ? pwdata[15:0] : 16'h0000;
    assign modeSel = smc_q[2:0];
    assign srcSel = smc_q[TSM_SMC_TS +: 3];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (clkEn) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(paddr[7:5] == 3'h0 && hit);
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    TSM_OFF_SMC: prdata <= {16'h0000, smc_q};
                    TSM_OFF_DIE: prdata <= {16'h0000, die_q};
                    TSM_OFF_STS: prdata <= {16'h0000, sts_q};
                    TSM_OFF_CTL: prdata <= {28'h0000000, ctl_q};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            smc_q <= TSM_SMC_RST;
            die_q <= TSM_DIE_RST;
        end else if (wrAcc && pready) begin
            if (paddr == TSM_OFF_SMC) begin
                smc_q <= pwdata[15:0];
            end
            if (paddr == TSM_OFF_DIE) begin
                die_q <= pwdata[15:0] & TSM_DIE_MASK;
            end
        end
    end

    // ****************************************************************
    // trigger selection and edge detection
    // ****************************************************************
    logic trigSel, trigDly_q, trigIn, trigPrev_q;
    logic trigRise, trigFall, slaveOn;

    always_comb begin
        case (srcSel)
            3'h0: trigSel = internalTriggerLine0;
            3'h1: trigSel = internalTriggerLine1;
            3'h4: trigSel = ch1EdgeDetect;
            3'h5: trigSel = ch1FilteredIn;
            3'h6: trigSel = ch2FilteredIn;
            3'h7: trigSel = filteredExtTrigger;
            default: trigSel = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            trigDly_q <= 1'b0;
            trigPrev_q <= 1'b0;
        end else if (clkEn) begin
            trigDly_q <= trigSel;
            trigPrev_q <= trigIn;
        end
    end

    assign trigIn = smc_q[TSM_SMC_MSM] ? trigDly_q : trigSel;
    assign trigRise = trigIn && !trigPrev_q;
    assign trigFall = !trigIn && trigPrev_q;
    assign slaveOn = modeSel != 3'(TSM_SM_OFF);

    // ****************************************************************
    // counter control
    // ****************************************************************
    logic ch1Prev_q, ch2Prev_q, ch1Edge, ch2Edge;
    logic tick, down, hwReinit, swUpdate, updSet;

    assign ch1Edge = ch1FilteredIn != ch1Prev_q;
    assign ch2Edge = ch2FilteredIn != ch2Prev_q;
    assign hwReinit = modeSel == 3'(TSM_SM_RESET) && trigRise;
    assign swUpdate = egrWr[0];

    // mode selection drives the count tick
    always_comb begin
        tick = 1'b0;
        down = ctl_q[TSM_CTL_DIR];
        case (modeSel)
            3'(TSM_SM_OFF), 3'(TSM_SM_RESET), 3'(TSM_SM_TRIG): tick = 1'b1;
            3'(TSM_SM_ENC1): begin
                tick = ch1Edge;
                down = ch1FilteredIn == ch2FilteredIn;
            end
            3'(TSM_SM_ENC2): begin
                tick = ch2Edge;
                down = ch1FilteredIn != ch2FilteredIn;
            end
            3'(TSM_SM_ENC3): begin
                tick = ch1Edge || ch2Edge;
                down = ch1Edge ? ch1FilteredIn == ch2FilteredIn
                               : ch1FilteredIn != ch2FilteredIn;
            end
            3'(TSM_SM_GATED): tick = trigIn;
            3'(TSM_SM_EXTCLK): tick = trigRise;
            default: tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctl_q <= TSM_CTL_RST;
        end else if (clkEn) begin
            if (wrAcc && pready && paddr == TSM_OFF_CTL) begin
                ctl_q <= pwdata[3:0];
            end
            if (modeSel == 3'(TSM_SM_TRIG) && trigRise) begin
                ctl_q[TSM_CTL_CEN] <= 1'b1;
            end
        end
    end

    assign updSet = !ctl_q[TSM_CTL_UPDATE_INHIBIT] &&
                    ((overflowEvent && repCountZero) ||
                     (!ctl_q[TSM_CTL_URS] && (swUpdate || hwReinit)));

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ch1Prev_q <= 1'b0;
            ch2Prev_q <= 1'b0;
            counterEnable <= 1'b0;
            counterTick <= 1'b0;
            countDown <= 1'b0;
            counterReinit <= 1'b0;
            reinitLoadsReload <= 1'b0;
            updateEvent <= 1'b0;
            chanCaptureNow <= '0;
            ocClear <= 1'b0;
        end else if (clkEn) begin
            ch1Prev_q <= ch1FilteredIn;
            ch2Prev_q <= ch2FilteredIn;
            counterEnable <= ctl_q[TSM_CTL_CEN];
            counterTick <= ctl_q[TSM_CTL_CEN] && tick;
            countDown <= down;
            counterReinit <= swUpdate || hwReinit;
            reinitLoadsReload <= ctl_q[TSM_CTL_DIR];
            updateEvent <= !ctl_q[TSM_CTL_UPDATE_INHIBIT] && (swUpdate || hwReinit ||
                           (overflowEvent && repCountZero));
            chanCaptureNow <= egrWr[TSM_STS_CCIF +: CHANNELS] & chanIsInput;
            ocClear <= smc_q[TSM_SMC_CLEAR_SOURCE_SELECT] ? comparatorOut
                                           : filteredExtTrigger;
        end
    end

    // ****************************************************************
    // status flags
    // ****************************************************************
    logic trigSet;
    logic [CHANNELS-1:0] ccSet, ocSet, capNow;
    logic [15:0] clrMask;

    assign trigSet = egrWr[TSM_STS_TIF] || (slaveOn &&
                     (trigRise || (modeSel == 3'(TSM_SM_GATED) && trigFall)));
    // match or capture sets channel flag
    assign capNow = chanIsInput &
                    (chanCaptureEvent | egrWr[TSM_STS_CCIF +: CHANNELS]);
    assign ccSet = capNow | (~chanIsInput & chanCompareMatch) |
                   egrWr[TSM_STS_CCIF +: CHANNELS];
    // overcapture on capture with flag set
    assign ocSet = capNow & sts_q[TSM_STS_CCIF +: CHANNELS];
    assign clrMask = (wrAcc && pready && paddr == TSM_OFF_STS)
                     ? ~pwdata[15:0] : 16'h0000;

    always_comb begin
        sts_d = sts_q & ~clrMask;
        sts_d[TSM_STS_CCIF +: CHANNELS] = sts_d[TSM_STS_CCIF +: CHANNELS] &
                                          ~(chanCaptureRead & chanIsInput);
        sts_d[TSM_STS_TIF] = sts_d[TSM_STS_TIF] | trigSet;
        sts_d[TSM_STS_UIF] = sts_d[TSM_STS_UIF] | updSet;
        sts_d[TSM_STS_CCIF +: CHANNELS] = sts_d[TSM_STS_CCIF +: CHANNELS] |
                                          ccSet;
        sts_d[TSM_STS_CCOF +: CHANNELS] = sts_d[TSM_STS_CCOF +: CHANNELS] |
                                          ocSet;
        sts_d = sts_d & TSM_STS_MASK;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sts_q <= TSM_STS_RST;
        end else if (clkEn) begin
            sts_q <= sts_d;
        end
    end

    // ****************************************************************
    // interrupt and DMA requests
    // ****************************************************************
    // interrupt requests follow flag and enable; DMA requests follow flag set events and enable
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            triggerIrq <= 1'b0;
            updateIrq <= 1'b0;
            chanIrq <= '0;
            triggerDma <= 1'b0;
            updateDma <= 1'b0;
            chanDma <= '0;
        end else if (clkEn) begin
            triggerIrq <= sts_d[TSM_STS_TIF] && die_q[TSM_DIE_TIE];
            updateIrq <= sts_d[TSM_STS_UIF] && die_q[TSM_DIE_UIE];
            chanIrq <= sts_d[TSM_STS_CCIF +: CHANNELS] &
                       die_q[TSM_DIE_CCIE +: CHANNELS];
            triggerDma <= trigSet && die_q[TSM_DIE_TDE];
            updateDma <= updSet && die_q[TSM_DIE_UDE];
            chanDma <= ccSet & die_q[TSM_DIE_CCDE +: CHANNELS];
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sync_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && smc_q[TSM_SMC_MSM] |-> trigIn == $past(trigSel))
        else $error("trigger not delayed");
    trig_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && trigSet |=> sts_q[TSM_STS_TIF])
        else $error("trigger flag not set");
    flag_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && clrMask[TSM_STS_TIF] && !trigSet |=> !sts_q[TSM_STS_TIF])
        else $error("flag not cleared");
    upd_inhibit_a: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && ctl_q[TSM_CTL_UPDATE_INHIBIT] |=> !updateEvent)
        else $error("update while inhibited");
    reset_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && hwReinit |=> counterReinit)
        else $error("reset mode no reinit");
    trig_start_a: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && modeSel == 3'(TSM_SM_TRIG) && trigRise
        |=> ctl_q[TSM_CTL_CEN])
        else $error("trigger mode no start");
    overcap_a: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && ocSet[0] |=> sts_q[TSM_STS_CCOF])
        else $error("overcapture lost");
    irq_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && !die_q[TSM_DIE_UIE] && $stable(die_q) |=> !updateIrq)
        else $error("update irq not gated");
endmodule

// File: tsm_trig_partner.sv
/*
 * Model of the two master timers whose trigger outputs drive internal
 * trigger lines 0 and 1 of the slave-mode block.
 * Assumes the bench raises a fire bit right after a rising clock edge.
 */
`timescale 1ns/1ps
module tsm_trig_partner (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [1:0] fire,
    output logic line0,
    output logic line1
);
    // ****************************************************************
    // master trigger outputs
    // ****************************************************************
    // first timer on line 0, second timer on line 1
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            line0 <= 1'b0;
            line1 <= 1'b0;
        end else begin
            line0 <= fire[0];
            line1 <= fire[1];
        end
    end
endmodule

// File: tsm_slave_ctrl_tb.sv
/*
 * Self-checking bench for the slave-mode, event and status block.
 * Assumes tsm_pkg and the trigger partner model are compiled first.
 */
`timescale 1ns/1ps
module tsm_slave_ctrl_tb;
    import tsm_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, cmpOut = 1'b0, ovf = 1'b0, repZero = 1'b0;
    logic [7:0] paddr = 8'h00, src = 8'h00;
    logic [31:0] pwdata = 32'h0, rdata, prdata;
    logic [3:0] chIn = 4'h0, chMatch = 4'h0, chCap = 4'h0, chRead = 4'h0;
    logic [3:0] capNow, chIrq, chDma;
    logic pready, pslverr, cntEn, tick, cntDown, reinit, loadRel, upd;
    logic ocClr, trIrq, upIrq, trDma, upDma, line0, line1, err;
    logic clkEn = 1'b1;
    int bad_count = 0, samples_checked = 0, cyc = 0, tickCyc = 0;
    int nTick = 0, nReinit = 0, nUpd = 0, nTrDma = 0, nUpDma = 0;
    int nChDma = 0, nCap = 0;

    tsm_slave_ctrl tsm_slave_ctrl_i (
        .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .internalTriggerLine0(line0),
        .internalTriggerLine1(line1), .ch1EdgeDetect(src[4]),
        .ch1FilteredIn(src[5]), .ch2FilteredIn(src[6]),
        .filteredExtTrigger(src[7]), .comparatorOut(cmpOut),
        .overflowEvent(ovf), .repCountZero(repZero), .chanIsInput(chIn),
        .chanCompareMatch(chMatch), .chanCaptureEvent(chCap),
        .chanCaptureRead(chRead), .counterEnable(cntEn),
        .counterTick(tick), .countDown(cntDown), .counterReinit(reinit),
        .reinitLoadsReload(loadRel), .updateEvent(upd),
        .chanCaptureNow(capNow), .ocClear(ocClr), .triggerIrq(trIrq),
        .updateIrq(upIrq), .chanIrq(chIrq), .triggerDma(trDma),
        .updateDma(upDma), .chanDma(chDma)
    );
    tsm_trig_partner tsm_trig_partner_i (
        .clk(clk), .reset_n(reset_n), .fire(src[1:0]), .line0(line0),
        .line1(line1)
    );

    // ****************************************************************
    // clock, event counters and timeout
    // ****************************************************************
    initial begin
        forever #10 clk = ~clk;
    end
    always @(negedge clk) begin
        cyc++;
        if (tick === 1'b1) begin
            nTick++;
            tickCyc = cyc;
        end
        nReinit += int'(reinit === 1'b1);
        nUpd += int'(upd === 1'b1);
        nTrDma += int'(trDma === 1'b1);
        nUpDma += int'(upDma === 1'b1);
        nChDma += $countones(chDma);
        nCap += $countones(capNow);
        if (cyc > 20000) begin
            bad_count++;
            end_sim();
        end
    end

    // ****************************************************************
    // expectations and bus tasks
    // ****************************************************************
    function automatic logic [31:0] dieExp(input logic [15:0] d);
        return {16'h0, d & 16'h5F5F};
    endfunction
    function automatic logic [31:0] extExp(input int ts, input int n);
        return (ts == 2 || ts == 3) ? 32'h0 : 32'(n);
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] want,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== want) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, want, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        chk("pready wait", 32'h1, 32'(n));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] want);
        apb(1'b0, a, 32'h0);
        chk(nm, want, rdata);
    endtask
    task automatic pulse(input int ts);
        src[ts] <= 1'b1;
        @(posedge clk);
        src[ts] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic mode(input logic [31:0] v);
        wr(TSM_OFF_SMC, 32'h0);
        wr(TSM_OFF_SMC, v);
        repeat (2) @(posedge clk);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        int n;
        int l0;
        logic [15:0] v;
        void'($urandom(32'hDB34));
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd("smc reset", TSM_OFF_SMC, 32'h0);
        rd("die reset", TSM_OFF_DIE, 32'h0);
        rd("sts reset", TSM_OFF_STS, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        v = 16'($urandom);
        wr(TSM_OFF_DIE, {16'h0, v});
        rd("die rw", TSM_OFF_DIE, dieExp(v));
        wr(TSM_OFF_CTL, 32'h1);
        l0 = nTick;
        repeat (10) @(posedge clk);
        chk("free ticks", 32'hA, 32'(nTick - l0));
        for (int ts = 0; ts < 8; ts++) begin
            mode(32'(ts * 16 + 7));
            n = 1 + int'($urandom % 4);
            l0 = nTick;
            repeat (n) pulse(ts);
            chk("ext ticks", extExp(ts, n), 32'(nTick - l0));
        end
        l0 = cyc;
        pulse(7);
        n = tickCyc - l0;
        wr(TSM_OFF_SMC, 32'hF7);
        l0 = cyc;
        pulse(7);
        chk("sync", 32'(TSM_SYNC_DELAY), 32'(tickCyc - l0 - n));
        wr(TSM_OFF_DIE, 32'h4000);
        mode(32'h75);
        l0 = nTick;
        n = nTrDma;
        src[7] <= 1'b1;
        repeat (6) @(posedge clk);
        src[7] <= 1'b0;
        repeat (4) @(posedge clk);
        chk("gated ticks", 32'h6, 32'(nTick - l0));
        chk("gated dma", 32'h2, 32'(nTrDma - n));
        for (int m = 1; m < 4; m++) begin
            mode(32'(m));
            l0 = nTick;
            repeat (8) begin
                if (src[5] == src[6]) begin
                    src[5] <= ~src[5];
                end else begin
                    src[6] <= ~src[6];
                end
                repeat (3) @(posedge clk);
            end
            chk("enc ticks", m == 3 ? 32'h8 : 32'h4, 32'(nTick - l0));
        end
        for (int k = 0; k < 2; k++) begin
            wr(TSM_OFF_CTL, k == 1 ? 32'h3 : 32'h1);
            mode(32'h04);
            wr(TSM_OFF_STS, 32'h0);
            l0 = nReinit;
            n = nUpd;
            pulse(0);
            chk("reset reinit", 32'h1, 32'(nReinit - l0));
            chk("reset upd", 32'(1 - k), 32'(nUpd - n));
            rd("reset sts", TSM_OFF_STS, k == 1 ? 32'h40 : 32'h41);
        end
        wr(TSM_OFF_CTL, 32'h0);
        mode(32'h16);
        l0 = nReinit;
        pulse(1);
        chk("trig cen", 32'h1, {31'h0, cntEn});
        chk("trig noreset", 32'h0, 32'(nReinit - l0));
        mode(32'h0);
        wr(TSM_OFF_CTL, 32'h8);
        wr(TSM_OFF_DIE, 32'h43);
        wr(TSM_OFF_STS, 32'h0);
        l0 = nReinit;
        wr(TSM_OFF_EGR, 32'h43);
        rd("egr read", TSM_OFF_EGR, 32'h0);
        rd("soft flags", TSM_OFF_STS, 32'h43);
        chk("irq lines", 32'h7, {29'h0, trIrq, chIrq[0], upIrq});
        chk("soft reinit", 32'h1, 32'(nReinit - l0));
        chk("reload", 32'h1, {31'h0, loadRel});
        chk("count dir", 32'h1, {31'h0, cntDown});
        wr(TSM_OFF_STS, 32'hFFBF);
        rd("w1 keeps", TSM_OFF_STS, 32'h3);
        chk("irq clear", 32'h0, {31'h0, trIrq});
        wr(TSM_OFF_CTL, 32'h4);
        wr(TSM_OFF_STS, 32'h0);
        wr(TSM_OFF_DIE, 32'h101);
        n = nUpDma;
        wr(TSM_OFF_EGR, 32'h1);
        rd("urs flag", TSM_OFF_STS, 32'h0);
        chk("urs dma", 32'h0, 32'(nUpDma - n));
        wr(TSM_OFF_CTL, 32'h0);
        wr(TSM_OFF_DIE, 32'h5F00);
        wr(TSM_OFF_STS, 32'h0);
        l0 = nTrDma + nUpDma;
        n = nChDma;
        wr(TSM_OFF_EGR, 32'h5F);
        rd("all flags", TSM_OFF_STS, 32'h5F);
        chk("tu dma", 32'h2, 32'(nTrDma + nUpDma - l0));
        chk("ch dma", 32'h4, 32'(nChDma - n));
        chk("no irq", 32'h0, {27'h0, trIrq, chIrq});
        chIn <= 4'h1;
        wr(TSM_OFF_STS, 32'h0);
        l0 = nCap;
        wr(TSM_OFF_EGR, 32'h2);
        wr(TSM_OFF_EGR, 32'h2);
        rd("overcapture", TSM_OFF_STS, 32'h202);
        chk("capture", 32'h2, 32'(nCap - l0));
        wr(TSM_OFF_STS, 32'h0);
        chCap <= 4'h1;
        chMatch <= 4'h2;
        @(posedge clk);
        chCap <= 4'h0;
        chMatch <= 4'h0;
        @(posedge clk);
        rd("cap match", TSM_OFF_STS, 32'h6);
        chRead <= 4'h3;
        @(posedge clk);
        chRead <= 4'h0;
        @(posedge clk);
        rd("read clear", TSM_OFF_STS, 32'h4);
        clkEn <= 1'b0;
        chCap <= 4'h1;
        @(posedge clk);
        clkEn <= 1'b1;
        chCap <= 4'h0;
        @(posedge clk);
        rd("frozen", TSM_OFF_STS, 32'h4);
        for (int k = 0; k < 3; k++) begin
            wr(TSM_OFF_CTL, k == 2 ? 32'h2 : 32'h0);
            wr(TSM_OFF_STS, 32'h0);
            n = nUpd;
            repZero <= (k != 1);
            ovf <= 1'b1;
            @(posedge clk);
            ovf <= 1'b0;
            @(posedge clk);
            rd("ovf flag", TSM_OFF_STS, k == 0 ? 32'h1 : 32'h0);
            chk("ovf upd", 32'(k == 0), 32'(nUpd - n));
        end
        repeat (4) begin
            v = 16'($urandom);
            cmpOut <= v[0];
            src[7] <= v[1];
            wr(TSM_OFF_SMC, {28'h0, v[2], 3'h0});
            repeat (2) @(posedge clk);
            chk("oc clear", {31'h0, v[2] ? v[0] : v[1]}, {31'h0, ocClr});
        end
        end_sim();
    end
endmodule
